// >>> rcf_pkg.sv
// reset-cause flag block: shared constants and carrier types
// assumes one 40 MHz clock and a plain register port of 8-bit data
package rcf_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_MASK = 8'h08;

    // ----------------------------------------
    // field positions of the flag register
    // ----------------------------------------
    localparam int BIT_STACK_OVERFLOW = 7;
    localparam int BIT_STACK_UNDERFLOW = 6;
    localparam int BIT_UNUSED = 5;
    localparam int BIT_WATCHDOG_N = 4;
    localparam int BIT_PIN_N = 3;
    localparam int BIT_INSTR_N = 2;
    localparam int BIT_POWERON_N = 1;
    localparam int BIT_BROWNOUT_N = 0;

    // ----------------------------------------
    // reset and mask values
    // ----------------------------------------
    // value after power-on: stack flags 0, active-low cause flags 1, status bits 0
    localparam logic [7:0] FLAGS_RESET = 8'h1c;
    // writable bits; bit 5 is not implemented
    localparam logic [7:0] FLAGS_IMPL = 8'hdf;
    // power-on counts as the first interrupt event
    localparam logic [7:0] INT_STATUS_RESET = 8'h02;
    localparam logic [7:0] INT_MASK_RESET = 8'h00;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic PIN_IDLE = 1'b1;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic stack_overflow;
        logic stack_underflow;
        logic watchdog;
        logic reset_instr;
        logic brownout;
    } rcf_events_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr_stb;
        logic rd_stb;
    } rcf_bus_t;

endpackage

// >>> rcf_reset_cause.sv
// reset-cause flag register with interrupt status, mask and register port
// assumes event inputs are one-cycle pulses on mclk; master-clear pin is asynchronous
`timescale 1ns/10ps

// Notes on behaviour
// - bit 7 stack overflow flag: hardware sets it, stays 1 until firmware writes 0
// - bit 6 stack underflow flag: hardware sets it, stays until firmware writes 0
// - bit 5 is not implemented: reads 0, writes ignored
// - watchdog flag is active low: cleared by watchdog reset, firmware writes 1
// - pin reset flag is active low: cleared by master-clear reset, firmware writes 1
// - reset-instruction flag active low: cleared by the instruction, firmware writes 1
// - power-on bit cleared on power-on reset; firmware must write it back to 1
// - brown-out bit 0 cleared on brown-out; firmware sets it after power-on or brown-out
// - power-on and brown-out reset stack flags to 0 and cause flags to 1
// - stack faults reset the device only while the stack-reset enable is set
module rcf_reset_cause (
    input wire logic mclk,
    input wire logic rst_n,
    input wire rcf_pkg::rcf_bus_t bus,
    input wire rcf_pkg::rcf_events_t events,
    input wire logic master_clear_pin,
    input wire logic stack_reset_enable,
    output logic [7:0] rd_data,
    output logic [7:0] power_reset_cause_flags,
    output logic stack_reset_req,
    output logic irq
);

    // ----------------------------------------
    // master-clear pin synchroniser
    // ----------------------------------------
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic pin_reset_evt;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= rcf_pkg::PIN_IDLE;
            pin_s2 <= rcf_pkg::PIN_IDLE;
            pin_prev <= rcf_pkg::PIN_IDLE;
        end else begin
            pin_s1 <= master_clear_pin;
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
        end
    end

    // pin is active low: a falling edge is one reset event
    assign pin_reset_evt = pin_prev & ~pin_s2;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic wr_flags;
    logic wr_int_status;
    logic wr_int_mask;

    assign wr_flags = bus.wr_stb && (bus.addr == rcf_pkg::ADDR_FLAGS);
    assign wr_int_status = bus.wr_stb && (bus.addr == rcf_pkg::ADDR_INT_STATUS);
    assign wr_int_mask = bus.wr_stb && (bus.addr == rcf_pkg::ADDR_INT_MASK);

    // ----------------------------------------
    // flag register
    // ----------------------------------------
    logic [7:0] next_flags;

    always_comb begin
        next_flags = power_reset_cause_flags;
        if (wr_flags) begin
            next_flags = bus.wdata & rcf_pkg::FLAGS_IMPL;
        end
        if (events.stack_overflow) begin
            next_flags[rcf_pkg::BIT_STACK_OVERFLOW] = 1'b1;
        end
        if (events.stack_underflow) begin
            next_flags[rcf_pkg::BIT_STACK_UNDERFLOW] = 1'b1;
        end
        if (events.watchdog) begin
            next_flags[rcf_pkg::BIT_WATCHDOG_N] = 1'b0;
        end
        if (pin_reset_evt) begin
            next_flags[rcf_pkg::BIT_PIN_N] = 1'b0;
        end
        if (events.reset_instr) begin
            next_flags[rcf_pkg::BIT_INSTR_N] = 1'b0;
        end
        if (events.brownout) begin
            next_flags[rcf_pkg::BIT_STACK_OVERFLOW] = 1'b0;
            next_flags[rcf_pkg::BIT_STACK_UNDERFLOW] = 1'b0;
            next_flags[rcf_pkg::BIT_WATCHDOG_N] = 1'b1;
            next_flags[rcf_pkg::BIT_PIN_N] = 1'b1;
            next_flags[rcf_pkg::BIT_INSTR_N] = 1'b1;
            next_flags[rcf_pkg::BIT_BROWNOUT_N] = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            power_reset_cause_flags <= rcf_pkg::FLAGS_RESET;
        end else begin
            power_reset_cause_flags <= next_flags;
        end
    end

    // ----------------------------------------
    // stack reset request
    // ----------------------------------------
    // gated by enable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stack_reset_req <= 1'b0;
        end else begin
            stack_reset_req <= stack_reset_enable && (events.stack_overflow || events.stack_underflow);
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    logic [7:0] int_status;
    logic [7:0] int_mask;
    logic [7:0] event_vec;
    logic [7:0] next_int_status;
    logic [7:0] next_int_mask;

    always_comb begin
        event_vec = rcf_pkg::DATA_ZERO;
        event_vec[rcf_pkg::BIT_STACK_OVERFLOW] = events.stack_overflow;
        event_vec[rcf_pkg::BIT_STACK_UNDERFLOW] = events.stack_underflow;
        event_vec[rcf_pkg::BIT_WATCHDOG_N] = events.watchdog;
        event_vec[rcf_pkg::BIT_PIN_N] = pin_reset_evt;
        event_vec[rcf_pkg::BIT_INSTR_N] = events.reset_instr;
        event_vec[rcf_pkg::BIT_BROWNOUT_N] = events.brownout;
    end

    always_comb begin
        next_int_status = int_status;
        if (wr_int_status) begin
            next_int_status = int_status & ~bus.wdata;
        end
        // set wins over write-one-to-clear
        next_int_status = (next_int_status | event_vec) & rcf_pkg::FLAGS_IMPL;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            int_status <= rcf_pkg::INT_STATUS_RESET;
        end else begin
            int_status <= next_int_status;
        end
    end

    always_comb begin
        next_int_mask = int_mask;
        if (wr_int_mask) begin
            next_int_mask = bus.wdata & rcf_pkg::FLAGS_IMPL;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            int_mask <= rcf_pkg::INT_MASK_RESET;
        end else begin
            int_mask <= next_int_mask;
        end
    end

    // level follows the registered status and mask with no lag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_int_status & next_int_mask);
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= rcf_pkg::DATA_ZERO;
        end else if (bus.rd_stb) begin
            case (bus.addr)
                rcf_pkg::ADDR_FLAGS: begin
                    rd_data <= power_reset_cause_flags;
                end
                rcf_pkg::ADDR_INT_STATUS: begin
                    rd_data <= int_status;
                end
                rcf_pkg::ADDR_INT_MASK: begin
                    rd_data <= int_mask;
                end
                default: begin
                    rd_data <= rcf_pkg::DATA_ZERO;
                end
            endcase
        end else begin
            rd_data <= rcf_pkg::DATA_ZERO;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_overflow_sets;
        @(posedge mclk) disable iff (!rst_n)
        events.stack_overflow && !events.brownout |=> power_reset_cause_flags[rcf_pkg::BIT_STACK_OVERFLOW];
    endproperty
    a_overflow_sets: assert property (p_overflow_sets) else $error("overflow flag not set");

    property p_underflow_sets;
        @(posedge mclk) disable iff (!rst_n)
        events.stack_underflow && !events.brownout |=> power_reset_cause_flags[rcf_pkg::BIT_STACK_UNDERFLOW];
    endproperty
    a_underflow_sets: assert property (p_underflow_sets) else $error("underflow flag not set");

    property p_unused_reads_zero;
        @(posedge mclk) disable iff (!rst_n)
        bus.rd_stb |=> !rd_data[rcf_pkg::BIT_UNUSED] && !power_reset_cause_flags[rcf_pkg::BIT_UNUSED];
    endproperty
    a_unused_reads_zero: assert property (p_unused_reads_zero) else $error("unused bit not zero");

    property p_watchdog_clears;
        @(posedge mclk) disable iff (!rst_n)
        events.watchdog && !events.brownout |=> !power_reset_cause_flags[rcf_pkg::BIT_WATCHDOG_N];
    endproperty
    a_watchdog_clears: assert property (p_watchdog_clears) else $error("watchdog flag not cleared");

    property p_pin_clears;
        @(posedge mclk) disable iff (!rst_n)
        $fell(pin_s2) && !events.brownout |=> !power_reset_cause_flags[rcf_pkg::BIT_PIN_N];
    endproperty
    a_pin_clears: assert property (p_pin_clears) else $error("pin flag not cleared");

    property p_instr_clears;
        @(posedge mclk) disable iff (!rst_n)
        events.reset_instr && !events.brownout |=> !power_reset_cause_flags[rcf_pkg::BIT_INSTR_N];
    endproperty
    a_instr_clears: assert property (p_instr_clears) else $error("instruction flag not cleared");

    property p_brownout_init;
        @(posedge mclk) disable iff (!rst_n)
        events.brownout |=> power_reset_cause_flags[7:6] == 2'b00 && power_reset_cause_flags[4:2] == 3'b111
            && !power_reset_cause_flags[rcf_pkg::BIT_BROWNOUT_N]
            && power_reset_cause_flags[rcf_pkg::BIT_POWERON_N]
            == $past(wr_flags ? bus.wdata[rcf_pkg::BIT_POWERON_N] : power_reset_cause_flags[rcf_pkg::BIT_POWERON_N]);
    endproperty
    a_brownout_init: assert property (p_brownout_init) else $error("brown-out values wrong");

    property p_stack_reset_gate;
        @(posedge mclk) disable iff (!rst_n)
        (events.stack_overflow || events.stack_underflow) |=> stack_reset_req == $past(stack_reset_enable);
    endproperty
    a_stack_reset_gate: assert property (p_stack_reset_gate) else $error("stack reset gating wrong");

    property p_event_beats_write;
        @(posedge mclk) disable iff (!rst_n)
        wr_flags && events.stack_overflow && !events.brownout
            |=> power_reset_cause_flags[rcf_pkg::BIT_STACK_OVERFLOW] ##1 1'b1;
    endproperty
    a_event_beats_write: assert property (p_event_beats_write) else $error("write beat hardware event");

    property p_flag_holds;
        @(posedge mclk) disable iff (!rst_n)
        !wr_flags && !events.brownout && !events.stack_overflow && power_reset_cause_flags[rcf_pkg::BIT_STACK_OVERFLOW]
            |=> power_reset_cause_flags[rcf_pkg::BIT_STACK_OVERFLOW];
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("overflow flag lost");

    property p_write_restores;
        @(posedge mclk) disable iff (!rst_n)
        wr_flags && !events.brownout && bus.wdata[rcf_pkg::BIT_POWERON_N]
            |=> power_reset_cause_flags[rcf_pkg::BIT_POWERON_N] [*2];
    endproperty
    a_write_restores: assert property (p_write_restores) else $error("power-on bit not kept");

    property p_brownout_status;
        @(posedge mclk) disable iff (!rst_n)
        wr_flags && !events.brownout && bus.wdata[rcf_pkg::BIT_BROWNOUT_N]
            |=> power_reset_cause_flags[rcf_pkg::BIT_BROWNOUT_N];
    endproperty
    a_brownout_status: assert property (p_brownout_status) else $error("brown-out bit not written");

    property p_read_flags;
        @(posedge mclk) disable iff (!rst_n)
        bus.rd_stb && bus.addr == rcf_pkg::ADDR_FLAGS |=> rd_data == $past(power_reset_cause_flags);
    endproperty
    a_read_flags: assert property (p_read_flags) else $error("flag read wrong");

    property p_irq_level;
        @(posedge mclk) disable iff (!rst_n)
        ##1 irq == |(int_status & int_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_stack_req_cause;
        @(posedge mclk) disable iff (!rst_n)
        stack_reset_req |-> $past(events.stack_overflow || events.stack_underflow);
    endproperty
    a_stack_req_cause: assert property (p_stack_req_cause) else $error("stack reset without fault");

    property p_watchdog_rearm;
        @(posedge mclk) disable iff (!rst_n)
        wr_flags && !events.watchdog && !events.brownout
            |=> power_reset_cause_flags[rcf_pkg::BIT_WATCHDOG_N] == $past(bus.wdata[rcf_pkg::BIT_WATCHDOG_N]);
    endproperty
    a_watchdog_rearm: assert property (p_watchdog_rearm) else $error("watchdog flag not written");

    property p_pin_rearm;
        @(posedge mclk) disable iff (!rst_n)
        wr_flags && !pin_reset_evt && !events.brownout
            |=> power_reset_cause_flags[rcf_pkg::BIT_PIN_N] == $past(bus.wdata[rcf_pkg::BIT_PIN_N]);
    endproperty
    a_pin_rearm: assert property (p_pin_rearm) else $error("pin flag not written");

    property p_instr_rearm;
        @(posedge mclk) disable iff (!rst_n)
        wr_flags && !events.reset_instr && !events.brownout
            |=> power_reset_cause_flags[rcf_pkg::BIT_INSTR_N] == $past(bus.wdata[rcf_pkg::BIT_INSTR_N]);
    endproperty
    a_instr_rearm: assert property (p_instr_rearm) else $error("instruction flag not written");

    property p_status_event_sets;
        @(posedge mclk) disable iff (!rst_n)
        |event_vec |=> (int_status & $past(event_vec)) == $past(event_vec);
    endproperty
    a_status_event_sets: assert property (p_status_event_sets) else $error("status bit lost its event");

    property p_rd_idle_zero;
        @(posedge mclk) disable iff (!rst_n)
        !bus.rd_stb |=> rd_data == rcf_pkg::DATA_ZERO;
    endproperty
    a_rd_idle_zero: assert property (p_rd_idle_zero) else $error("read data not idle");

    property p_unused_status_zero;
        @(posedge mclk) disable iff (!rst_n)
        !int_status[rcf_pkg::BIT_UNUSED] && !int_mask[rcf_pkg::BIT_UNUSED];
    endproperty
    a_unused_status_zero: assert property (p_unused_status_zero) else $error("unused status bit set");

endmodule

// >>> rcf_reset_cause_tb.sv
// self-checking testbench for the reset-cause flag block with a queue-free integer model
// assumes rcf_pkg and rcf_reset_cause are compiled first; one 40 MHz clock
`timescale 1ns/10ps

module rcf_reset_cause_tb;
    // ----------------------------------------
    // stimulus, outputs and model state
    // ----------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic master_clear_pin = 1'b1;
    logic stack_reset_enable = 1'b0;
    rcf_pkg::rcf_bus_t bus = '0;
    rcf_pkg::rcf_events_t events = '0;
    logic [7:0] rd_data;
    logic [7:0] power_reset_cause_flags;
    logic stack_reset_req;
    logic irq;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] seed = 8'h0f;
    logic [7:0] m_flags = rcf_pkg::FLAGS_RESET;
    logic [7:0] m_st = rcf_pkg::INT_STATUS_RESET;
    logic [7:0] m_mask = rcf_pkg::INT_MASK_RESET;
    // flag bit for each event input, indexed by event bit
    logic [7:0] hw_bit [0:4] = '{8'h01, 8'h04, 8'h10, 8'h40, 8'h80};
    logic [7:0] addrs [0:2] = '{rcf_pkg::ADDR_FLAGS, rcf_pkg::ADDR_INT_STATUS, rcf_pkg::ADDR_INT_MASK};

    always #12.5 mclk = ~mclk;

    rcf_reset_cause uut (
        .mclk(mclk),
        .rst_n(rst_n),
        .bus(bus),
        .events(events),
        .master_clear_pin(master_clear_pin),
        .stack_reset_enable(stack_reset_enable),
        .rd_data(rd_data),
        .power_reset_cause_flags(power_reset_cause_flags),
        .stack_reset_req(stack_reset_req),
        .irq(irq)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function logic [7:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 5);
        seed = seed ^ (seed << 3);
        return seed;
    endfunction

    function logic [7:0] m_read(input logic [7:0] a);
        case (a)
            rcf_pkg::ADDR_FLAGS: return m_flags;
            rcf_pkg::ADDR_INT_STATUS: return m_st;
            rcf_pkg::ADDR_INT_MASK: return m_mask;
            default: return 8'h00;
        endcase
    endfunction

    task print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one bus cycle plus event pulses, then model update and compare
    task op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r, input logic [4:0] ev);
        logic [7:0] exp_rd;
        logic exp_irq;
        exp_rd = r ? m_read(a) : 8'h00;
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr_stb: w, rd_stb: r};
        events <= ev;
        @(posedge mclk);
        bus <= '0;
        events <= '0;
        #1;
        if (w && a == rcf_pkg::ADDR_FLAGS) m_flags = d & rcf_pkg::FLAGS_IMPL;
        if (w && a == rcf_pkg::ADDR_INT_STATUS) m_st = m_st & ~d;
        if (w && a == rcf_pkg::ADDR_INT_MASK) m_mask = d & rcf_pkg::FLAGS_IMPL;
        // hardware events applied after the write
        for (int i = 1; i < 5; i++) begin
            if (ev[i]) begin
                m_st = m_st | hw_bit[i];
                m_flags = (i >= 3) ? (m_flags | hw_bit[i]) : (m_flags & ~hw_bit[i]);
            end
        end
        if (ev[0]) begin
            m_st = m_st | 8'h01;
            m_flags = (m_flags & 8'h02) | 8'h1c;
        end
        // level tracks the status and mask as they stand after this edge
        exp_irq = |(m_st & m_mask);
        chk("flags", power_reset_cause_flags, m_flags);
        chk("rd_data", rd_data, exp_rd);
        chk("irq", {7'h00, irq}, {7'h00, exp_irq});
        chk("stack_req", {7'h00, stack_reset_req}, {7'h00, stack_reset_enable & (ev[4] | ev[3])});
    endtask

    // ----------------------------------------
    // hang guard
    // ----------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] r8;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        // values after power-on and unmapped read
        for (int k = 0; k < 3; k++) begin
            op(addrs[k], 8'h00, 1'b0, 1'b1, 5'h00);
        end
        op(8'h0c, 8'h00, 1'b0, 1'b1, 5'h00);
        // mask in, firmware re-arm of status bits, bit 5 ignored
        op(rcf_pkg::ADDR_INT_MASK, 8'hff, 1'b1, 1'b0, 5'h00);
        op(rcf_pkg::ADDR_FLAGS, 8'hff, 1'b1, 1'b0, 5'h00);
        op(rcf_pkg::ADDR_FLAGS, 8'h00, 1'b0, 1'b1, 5'h00);
        op(rcf_pkg::ADDR_INT_STATUS, 8'hff, 1'b1, 1'b0, 5'h00);
        op(rcf_pkg::ADDR_INT_MASK, 8'h00, 1'b0, 1'b1, 5'h00);
        // each event with a clashing random write, enable off then on
        for (int en = 0; en < 2; en++) begin
            @(posedge mclk);
            stack_reset_enable <= en[0];
            for (int i = 0; i < 5; i++) begin
                op(rcf_pkg::ADDR_FLAGS, xs(), 1'b1, 1'b0, 5'b00001 << i);
                op(rcf_pkg::ADDR_INT_STATUS, 8'h00, 1'b0, 1'b1, 5'h00);
                op(rcf_pkg::ADDR_INT_STATUS, 8'hff, 1'b1, 1'b0, 5'h00);
            end
        end
        // master-clear pin event through the synchroniser
        @(posedge mclk);
        master_clear_pin <= 1'b0;
        repeat (5) @(posedge mclk);
        master_clear_pin <= 1'b1;
        #1;
        m_flags = m_flags & ~8'h08;
        m_st = m_st | 8'h08;
        op(rcf_pkg::ADDR_FLAGS, 8'h00, 1'b0, 1'b1, 5'h00);
        op(rcf_pkg::ADDR_INT_STATUS, 8'h00, 1'b0, 1'b1, 5'h00);
        // random writes and mixed simultaneous events
        repeat (24) begin
            r8 = xs();
            op(addrs[r8 % 3], xs(), 1'b1, 1'b0, r8[7:3]);
            op(addrs[r8 % 3], 8'h00, 1'b0, 1'b1, 5'h00);
        end
        print_verdict();
    end
endmodule
